/* core/ibr_decode.sv */
/*
 Instrument bus register decode: one module holding every host-written
 control register and the read-back multiplexer.
 Assumes the host presents address and data with a one-cycle write or
 read strobe synchronous to mclk; it is the only bus master.
*/
//
// Contract
// - Steer bit set: low three bits to bandwidth
// - Steer bit clear: low seven bits to gain
// - Both share one address, steer bit selects
// - Bandwidth has five decade settings; code stores any 3-bit value
// - Nine bands, gain zero to forty dB
// - Video offset full byte, quarter dB
// - Stretcher, identify offset, deflection mode bits
// - Low nibble holds log scale factor
// - One register: clamp, filter, leveling
// - Storage data written and read back
// - Separate storage control register
// - Intensity/RF write, supply status read
// - Readout control plus character data registers
// - Two sweep control registers
// - Span attenuator at two consecutive addresses
// - First LO control plus tracking adjust
// - Presence read drives only bit 3
// - DAC control, data, compare read
// - Preload write; three ordered status reads
// - Front panel read returns encoders
// - Bit 0 switches base-line leveling
// - Bit 7 enables storage acquisition
// - Extended address selects subaddress; 6 hands off
`timescale 1ns/100ps

module ibr_decode #(
    parameter int unsigned NUM_BANDS = 9
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst,
    // Instrument bus
    input  wire logic [ibr_pkg::ADDR_W-1:0]   busAddr,
    input  wire logic [ibr_pkg::DATA_W-1:0]   busWrData,
    input  wire logic                         busWrStb,
    input  wire logic                         busRdStb,
    output logic      [ibr_pkg::DATA_W-1:0]   busRdData,
    output logic                              busRdValid,
    // Status sources from the boards
    input  wire logic [7:0]                   psuStatus,
    input  wire logic [7:0]                   dacCompare,
    input  wire logic [23:0]                  pllCounter,
    input  wire logic [7:0]                   pllFlags,
    input  wire logic [7:0]                   panelEncoders,
    input  wire logic [7:0]                   storeReadData,
    input  wire logic                         pllSelReset,
    // Variable resolution section
    output logic      [2:0]                   rbwSelect,
    output logic      [6:0]                   gainLevel,
    // Log and video amplifier
    output logic      [7:0]                   videoOffset,
    output logic                              pulseStretch,
    output logic                              identOffset,
    output logic      [1:0]                   deflectMode,
    output logic      [3:0]                   logScale,
    // Video processor
    output logic      [7:0]                   videoProc,
    output logic                              baseLevelOn,
    // Digital storage
    output logic      [7:0]                   storeWrData,
    output logic                              storeWrStb,
    output logic      [7:0]                   storeCtl,
    output logic                              storeAcqEn,
    output logic      [2:0]                   storeSubAddr,
    output logic                              storeVertical,
    // Other boards
    output logic      [7:0]                   intensRf,
    output logic      [7:0]                   readoutCtl,
    output logic      [7:0]                   charData,
    output logic                              charStb,
    output logic      [15:0]                  sweepCtl,
    output logic      [15:0]                  spanAtten,
    output logic      [7:0]                   firstLoCtl,
    output logic      [7:0]                   trackingAdjust,
    output logic      [7:0]                   preselCtl,
    output logic      [7:0]                   dacCtl,
    output logic      [7:0]                   dacData,
    output logic      [7:0]                   pllPreload,
    output logic                              pllPreloadStb,
    output logic      [7:0]                   auxSynth
);
    import ibr_pkg::*;

    default clocking chkClk @(posedge mclk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  rbw;
        logic [6:0]  gain;
        logic [7:0]  vidOff;
        logic [7:0]  disp;
        logic [7:0]  vproc;
        logic [7:0]  sdata;
        logic        sstb;
        logic [7:0]  sctl;
        logic        svert;
        logic [7:0]  irf;
        logic [7:0]  rctl;
        logic [7:0]  chr;
        logic        cstb;
        logic [15:0] sweep;
        logic [15:0] span;
        logic [7:0]  flo;
        logic [7:0]  trk;
        logic [7:0]  psel;
        logic [7:0]  dctl;
        logic [7:0]  ddat;
        logic [7:0]  pre;
        logic        pstb;
        logic [7:0]  aux;
        logic [1:0]  pllSel;
        logic [7:0]  rd;
        logic        rdv;
    } ibr_state_s;

    ibr_state_s st_q;
    ibr_state_s st_d;

    // Deflection field sits above the log scale nibble
    function automatic logic [1:0] deflField(input logic [7:0] v);
        deflField = v[5:4];
    endfunction

    // Read counterpart: same register, flag bit set
    function automatic logic isRead(input logic [7:0] a, input logic [7:0] base);
        isRead = (a == (base | ADR_READ_FLAG));
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        st_d.sstb = 1'b0;
        st_d.cstb = 1'b0;
        st_d.pstb = 1'b0;
        st_d.rdv  = 1'b0;
        if (pllSelReset) begin
            st_d.pllSel = PLL_SEL_RESET;
        end
        if (busWrStb && !busAddr[7]) begin
            case (busAddr)
                ADR_RES_GAIN: begin
                    if (busWrData[BIT_STEER]) begin
                        st_d.rbw = busWrData[2:0];
                    end else begin
                        st_d.gain = busWrData[6:0];
                    end
                end
                ADR_VID_OFFSET:  st_d.vidOff = busWrData;
                ADR_DISP_MODE:   st_d.disp = busWrData;
                ADR_VID_PROC:    st_d.vproc = busWrData;
                ADR_STORE_DATA: begin
                    st_d.sdata = busWrData;
                    st_d.sstb  = 1'b1;
                end
                ADR_STORE_CTL: begin
                    st_d.sctl  = busWrData;
                    st_d.svert = (busWrData[6:4] == SUB_VERTICAL);
                end
                ADR_INTENS_RF:   st_d.irf = busWrData;
                ADR_READOUT_CTL: st_d.rctl = busWrData;
                ADR_CHAR_DATA: begin
                    st_d.chr  = busWrData;
                    st_d.cstb = 1'b1;
                end
                ADR_SWEEP_A:     st_d.sweep[7:0] = busWrData;
                ADR_SWEEP_B:     st_d.sweep[15:8] = busWrData;
                ADR_SPAN_A:      st_d.span[7:0] = busWrData;
                ADR_SPAN_B:      st_d.span[15:8] = busWrData;
                ADR_FIRST_LO:    st_d.flo = busWrData;
                ADR_TRACK_ADJ:   st_d.trk = busWrData;
                ADR_PRESEL:      st_d.psel = busWrData;
                ADR_DAC_CTL:     st_d.dctl = busWrData;
                ADR_DAC_DATA:    st_d.ddat = busWrData;
                ADR_PLL_PRELOAD: begin
                    st_d.pre  = busWrData;
                    st_d.pstb = 1'b1;
                end
                // Values are passed as written; the host keeps N and A legal
                ADR_AUX_SYNTH:   st_d.aux = busWrData;
                default: begin
                end
            endcase
        end
        if (busRdStb && busAddr[7]) begin
            st_d.rdv = 1'b1;
            st_d.rd  = REG_RESET;
            if (isRead(busAddr, ADR_INTENS_RF)) begin
                st_d.rd = psuStatus;
            end else if (isRead(busAddr, ADR_DAC_CTL)) begin
                st_d.rd = dacCompare;
            end else if (isRead(busAddr, ADR_PLL_PRELOAD)) begin
                // Status and top counter bits first, then lower bytes
                case (st_q.pllSel)
                    2'h0:    st_d.rd = pllFlags | pllCounter[23:16];
                    2'h1:    st_d.rd = pllCounter[15:8];
                    default: st_d.rd = pllCounter[7:0];
                endcase
                if (!pllSelReset && st_q.pllSel < 2'(PLL_READS - 1)) begin
                    st_d.pllSel = st_q.pllSel + 2'h1;
                end
            end else if (busAddr == ADR_FRONT_PANEL) begin
                st_d.rd = panelEncoders;
            end else if (isRead(busAddr, ADR_PRESEL)) begin
                st_d.rd = PRESENT_MASK;
            end else if (isRead(busAddr, ADR_STORE_DATA)) begin
                st_d.rd = storeReadData;
            end
        end
        if (rst) begin
            st_d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        st_q <= st_d;
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign rbwSelect      = st_q.rbw;
    assign gainLevel      = st_q.gain;
    assign videoOffset    = st_q.vidOff;
    assign pulseStretch   = st_q.disp[BIT_STRETCH];
    assign identOffset    = st_q.disp[BIT_IDENT];
    assign deflectMode    = deflField(st_q.disp);
    assign logScale       = st_q.disp[3:0];
    assign videoProc      = st_q.vproc;
    assign baseLevelOn    = st_q.vproc[BIT_LEVEL];
    assign storeWrData    = st_q.sdata;
    assign storeWrStb     = st_q.sstb;
    assign storeCtl       = st_q.sctl;
    assign storeAcqEn     = st_q.sctl[BIT_ACQ];
    assign storeSubAddr   = st_q.sctl[6:4];
    assign storeVertical  = st_q.svert;
    assign intensRf       = st_q.irf;
    assign readoutCtl     = st_q.rctl;
    assign charData       = st_q.chr;
    assign charStb        = st_q.cstb;
    assign sweepCtl       = st_q.sweep;
    assign spanAtten      = st_q.span;
    assign firstLoCtl     = st_q.flo;
    assign trackingAdjust = st_q.trk;
    assign preselCtl      = st_q.psel;
    assign dacCtl         = st_q.dctl;
    assign dacData        = st_q.ddat;
    assign pllPreload     = st_q.pre;
    assign pllPreloadStb  = st_q.pstb;
    assign auxSynth       = st_q.aux;
    assign busRdData      = st_q.rd;
    assign busRdValid     = st_q.rdv;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_rbw_steer: assert property (
        busWrStb && busAddr == ADR_RES_GAIN && busWrData[BIT_STEER]
        |=> rbwSelect == $past(busWrData[2:0]) && gainLevel == $past(gainLevel))
        else $error("bandwidth steer wrong");

    chk_gain_steer: assert property (
        busWrStb && busAddr == ADR_RES_GAIN && !busWrData[BIT_STEER]
        |=> gainLevel == $past(busWrData[6:0]) && rbwSelect == $past(rbwSelect))
        else $error("gain steer wrong");

    chk_offset_write: assert property (
        busWrStb && busAddr == ADR_VID_OFFSET |=> videoOffset == $past(busWrData))
        else $error("video offset not stored");

    chk_disp_fields: assert property (
        busWrStb && busAddr == ADR_DISP_MODE
        |=> {pulseStretch, identOffset, deflectMode, logScale} == $past(busWrData))
        else $error("display mode fields wrong");

    chk_level_bit: assert property (
        busWrStb && busAddr == ADR_VID_PROC |=> baseLevelOn == $past(busWrData[BIT_LEVEL]))
        else $error("leveling bit wrong");

    chk_acq_enable: assert property (
        busWrStb && busAddr == ADR_STORE_CTL
        |=> storeAcqEn == $past(busWrData[BIT_ACQ]) && storeVertical == ($past(busWrData[6:4]) == SUB_VERTICAL))
        else $error("storage control wrong");

    chk_presence_read: assert property (
        busRdStb && busAddr == ADR_PRESENCE |=> busRdValid && busRdData == PRESENT_MASK)
        else $error("presence read wrong");

    // Selector reset, then the first read must give the status byte
    chk_pll_order: assert property (
        ($fell(pllSelReset) && !(busRdStb && busAddr == ADR_PLL_STATUS))
        ##1 (busRdStb && busAddr == ADR_PLL_STATUS && !pllSelReset)
        |=> busRdData == ($past(pllFlags) | $past(pllCounter[23:16])))
        else $error("phase lock first read wrong");

    chk_read_no_write: assert property (
        busWrStb && busAddr[7]
        |=> intensRf == $past(intensRf) && videoOffset == $past(videoOffset))
        else $error("read address wrote a register");

    chk_panel_read: assert property (
        busRdStb && busAddr == ADR_FRONT_PANEL |=> busRdData == $past(panelEncoders))
        else $error("front panel read wrong");

    chk_psu_read: assert property (
        busRdStb && busAddr == ADR_PSU_STATUS |=> busRdValid && busRdData == $past(psuStatus))
        else $error("supply status read wrong");

    chk_dac_read: assert property (
        busRdStb && busAddr == ADR_DAC_CMP |=> busRdValid && busRdData == $past(dacCompare))
        else $error("compare read wrong");

    chk_store_read: assert property (
        busRdStb && busAddr == ADR_STORE_READ |=> busRdValid && busRdData == $past(storeReadData))
        else $error("storage read wrong");

    chk_read_refused: assert property (
        busRdStb && !busAddr[7] |=> !busRdValid)
        else $error("low address read answered");

    chk_store_strobe: assert property (
        busWrStb && busAddr == ADR_STORE_DATA |=> storeWrStb && storeWrData == $past(busWrData))
        else $error("storage write strobe wrong");

    chk_char_strobe: assert property (
        busWrStb && busAddr == ADR_CHAR_DATA |=> charStb && charData == $past(busWrData))
        else $error("character strobe wrong");

    chk_preload_strobe: assert property (
        busWrStb && busAddr == ADR_PLL_PRELOAD |=> pllPreloadStb && pllPreload == $past(busWrData))
        else $error("preload strobe wrong");

    chk_sweep_write: assert property (
        busWrStb && busAddr == ADR_SWEEP_B |=> sweepCtl == {$past(busWrData), $past(sweepCtl[7:0])})
        else $error("sweep high byte wrong");

    chk_span_write: assert property (
        busWrStb && busAddr == ADR_SPAN_A |=> spanAtten == {$past(spanAtten[15:8]), $past(busWrData)})
        else $error("span low byte wrong");

    chk_track_write: assert property (
        busWrStb && busAddr == ADR_TRACK_ADJ |=> trackingAdjust == $past(busWrData))
        else $error("tracking adjust wrong");

    chk_lo_write: assert property (
        busWrStb && busAddr == ADR_FIRST_LO |=> firstLoCtl == $past(busWrData))
        else $error("oscillator control wrong");

    chk_readout_write: assert property (
        busWrStb && busAddr == ADR_READOUT_CTL |=> readoutCtl == $past(busWrData))
        else $error("readout control wrong");

    cov_rbw_write: cover property (@(posedge mclk) busWrStb && busAddr == ADR_RES_GAIN && busWrData[7]);
    cov_gain_write: cover property (@(posedge mclk) busWrStb && busAddr == ADR_RES_GAIN && !busWrData[7]);
    cov_pll_three: cover property (@(posedge mclk)
        (busRdStb && busAddr == ADR_PLL_STATUS) ##2 (busRdStb && busAddr == ADR_PLL_STATUS)
        ##2 (busRdStb && busAddr == ADR_PLL_STATUS));
    cov_vertical: cover property (@(posedge mclk) storeVertical);

endmodule // ibr_decode

/* core/ibr_pkg.sv */
/*
 Constants for the instrument bus register decode: bus addresses,
 field positions and reset values.
 Assumes an 8-bit address and 8-bit data instrument bus, one master.
*/
package ibr_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ------------------------------------------------------------
    // Write addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_SWEEP_A     = 8'h0f;
    localparam logic [7:0] ADR_SWEEP_B     = 8'h1f;
    localparam logic [7:0] ADR_CHAR_DATA   = 8'h2f;
    localparam logic [7:0] ADR_RES_GAIN    = 8'h3f;
    localparam logic [7:0] ADR_INTENS_RF   = 8'h4f;
    localparam logic [7:0] ADR_READOUT_CTL = 8'h5f;
    localparam logic [7:0] ADR_DAC_CTL     = 8'h70;
    localparam logic [7:0] ADR_DAC_DATA    = 8'h71;
    localparam logic [7:0] ADR_FIRST_LO    = 8'h72;
    localparam logic [7:0] ADR_PLL_PRELOAD = 8'h73;
    localparam logic [7:0] ADR_SPAN_A      = 8'h75;
    localparam logic [7:0] ADR_SPAN_B      = 8'h76;
    localparam logic [7:0] ADR_PRESEL      = 8'h77;
    localparam logic [7:0] ADR_VID_OFFSET  = 8'h78;
    localparam logic [7:0] ADR_DISP_MODE   = 8'h79;
    localparam logic [7:0] ADR_STORE_DATA  = 8'h7a;
    localparam logic [7:0] ADR_STORE_CTL   = 8'h7b;
    localparam logic [7:0] ADR_VID_PROC    = 8'h7c;
    localparam logic [7:0] ADR_AUX_SYNTH   = 8'h7d;
    localparam logic [7:0] ADR_TRACK_ADJ   = 8'h7e;

    // ------------------------------------------------------------
    // Read addresses (write address with bit 7 set, except front panel 8'hf4, which has no write address)
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_READ_FLAG   = 8'h80;
    localparam logic [7:0] ADR_PSU_STATUS  = 8'hcf;
    localparam logic [7:0] ADR_DAC_CMP     = 8'hf0;
    localparam logic [7:0] ADR_PLL_STATUS  = 8'hf3;
    localparam logic [7:0] ADR_FRONT_PANEL = 8'hf4;
    localparam logic [7:0] ADR_PRESENCE    = 8'hf7;
    localparam logic [7:0] ADR_STORE_READ  = 8'hfa;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int unsigned BIT_STEER      = 7;
    localparam int unsigned BIT_STRETCH    = 7;
    localparam int unsigned BIT_IDENT      = 6;
    localparam int unsigned BIT_LEVEL      = 0;
    localparam int unsigned BIT_ACQ        = 7;
    localparam int unsigned BIT_PRESENT    = 3;
    localparam int unsigned RBW_SETTINGS   = 5;
    localparam logic [2:0]  SUB_VERTICAL   = 3'h6;
    localparam logic [7:0]  PRESENT_MASK   = 8'h08;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic [2:0]  RBW_RESET      = 3'h0;
    localparam logic [6:0]  GAIN_RESET     = 7'h00;
    localparam int unsigned PLL_READS      = 3;
    localparam logic [1:0]  PLL_SEL_RESET  = 2'h0;

endpackage : ibr_pkg

/* test/ibr_host_model.sv */
/*
 Host model: the only master of the instrument bus, one cycle at a time.
 Assumes the decode takes a strobe at the rising mclk edge.
*/
`timescale 1ns/100ps

module ibr_host_model (
    // Clock
    input  wire logic       mclk,
    // Instrument bus
    output logic      [7:0] busAddr,
    output logic      [7:0] busWrData,
    output logic            busWrStb,
    output logic            busRdStb,
    input  wire logic [7:0] busRdData,
    input  wire logic       busRdValid
);
    initial begin
        busAddr   = 8'h00;
        busWrData = 8'h00;
        busWrStb  = 1'b0;
        busRdStb  = 1'b0;
    end

    // ----
    // Bus cycles
    // ----
    // Released lines show the inverse so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        busAddr   <= a;
        busWrData <= d;
        busWrStb  <= 1'b1;
        @(posedge mclk);
        busWrStb  <= 1'b0;
        busAddr   <= ~a;
        busWrData <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge mclk);
        busAddr  <= a;
        busRdStb <= 1'b1;
        @(posedge mclk);
        busRdStb <= 1'b0;
        busAddr  <= ~a;
        @(negedge mclk);
        ok = busRdValid;
        d  = busRdData;
    endtask
endmodule // ibr_host_model

/* test/testbench.sv */
/*
 Testbench for the instrument bus register decode.
 Assumes ibr_host_model as bus master; status inputs held by the bench.
*/
`timescale 1ns/100ps

module testbench;
    import ibr_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } ibr_row_s;

    logic        mclk, rst, busWrStb, busRdStb, busRdValid, pllSelReset, rdOk;
    logic [7:0]  busAddr, busWrData, busRdData, psuStatus, dacCompare, pllFlags, panelEncoders, storeReadData;
    logic [23:0] pllCounter;
    logic [2:0]  rbwSelect, storeSubAddr;
    logic [6:0]  gainLevel;
    logic [1:0]  deflectMode;
    logic [3:0]  logScale;
    logic        pulseStretch, identOffset, baseLevelOn, storeWrStb, storeAcqEn, storeVertical, charStb, pllPreloadStb;
    logic [7:0]  videoOffset, videoProc, storeWrData, storeCtl, intensRf, readoutCtl, charData, firstLoCtl;
    logic [7:0]  trackingAdjust, preselCtl, dacCtl, dacData, pllPreload, auxSynth, rdVal;
    logic [15:0] sweepCtl, spanAtten;
    int          errors, cmp_count;

    // ----
    // Case tables
    // ----
    localparam ibr_row_s WR_ROWS [19] = '{
        '{8'h0f, 8'ha1, 8'ha1}, '{8'h1f, 8'hb2, 8'hb2}, '{8'h2f, 8'hc3, 8'hc3}, '{8'h4f, 8'hd4, 8'hd4},
        '{8'h5f, 8'he5, 8'he5}, '{8'h70, 8'h16, 8'h16}, '{8'h71, 8'h27, 8'h27}, '{8'h72, 8'h38, 8'h38},
        '{8'h73, 8'h49, 8'h49}, '{8'h75, 8'h5a, 8'h5a}, '{8'h76, 8'h6b, 8'h6b}, '{8'h77, 8'h7c, 8'h7c},
        '{8'h78, 8'hff, 8'hff}, '{8'h79, 8'ha5, 8'ha5}, '{8'h7a, 8'h9e, 8'h9e}, '{8'h7b, 8'he0, 8'he0},
        '{8'h7c, 8'h01, 8'h01}, '{8'h7d, 8'h9f, 8'h9f}, '{8'h7e, 8'h4d, 8'h4d}};
    localparam ibr_row_s RD_ROWS [7] = '{'{8'hf7, 8'h00, 8'h08}, '{8'hcf, 8'h00, 8'h3c}, '{8'hf0, 8'h00, 8'hc5},
        '{8'hf4, 8'h00, 8'h96}, '{8'hfa, 8'h00, 8'h69}, '{8'h81, 8'h00, 8'h00}, '{8'hce, 8'h00, 8'h00}};
    localparam logic [7:0] STEER_DAT [3] = '{8'h85, 8'h7f, 8'h84};
    localparam logic [9:0] STEER_EXP [3] = '{{3'h5, 7'h00}, {3'h5, 7'h7f}, {3'h4, 7'h7f}};
    localparam logic [7:0] STB_ADR [3] = '{8'h7a, 8'h2f, 8'h73};
    localparam logic [2:0] STB_EXP [3] = '{3'h4, 3'h2, 3'h1};
    localparam logic [7:0] PLL_EXP [4] = '{8'h5a, 8'hb1, 8'hc2, 8'hc2};

    ibr_host_model host_u (.mclk(mclk), .busAddr(busAddr), .busWrData(busWrData), .busWrStb(busWrStb),
        .busRdStb(busRdStb), .busRdData(busRdData), .busRdValid(busRdValid));

    ibr_decode dut_u (.mclk(mclk), .rst(rst), .busAddr(busAddr), .busWrData(busWrData), .busWrStb(busWrStb),
        .busRdStb(busRdStb), .busRdData(busRdData), .busRdValid(busRdValid), .psuStatus(psuStatus),
        .dacCompare(dacCompare), .pllCounter(pllCounter), .pllFlags(pllFlags), .panelEncoders(panelEncoders),
        .storeReadData(storeReadData), .pllSelReset(pllSelReset), .rbwSelect(rbwSelect), .gainLevel(gainLevel),
        .videoOffset(videoOffset), .pulseStretch(pulseStretch), .identOffset(identOffset),
        .deflectMode(deflectMode), .logScale(logScale), .videoProc(videoProc), .baseLevelOn(baseLevelOn),
        .storeWrData(storeWrData), .storeWrStb(storeWrStb), .storeCtl(storeCtl), .storeAcqEn(storeAcqEn),
        .storeSubAddr(storeSubAddr), .storeVertical(storeVertical), .intensRf(intensRf),
        .readoutCtl(readoutCtl), .charData(charData), .charStb(charStb), .sweepCtl(sweepCtl),
        .spanAtten(spanAtten), .firstLoCtl(firstLoCtl), .trackingAdjust(trackingAdjust), .preselCtl(preselCtl),
        .dacCtl(dacCtl), .dacData(dacData), .pllPreload(pllPreload), .pllPreloadStb(pllPreloadStb),
        .auxSynth(auxSynth));

    // ----
    // Helpers
    // ----
    function automatic logic [7:0] seenFor(input logic [7:0] a);
        case (a)
            8'h0f: return sweepCtl[7:0];
            8'h1f: return sweepCtl[15:8];
            8'h2f: return charData;
            8'h4f: return intensRf;
            8'h5f: return readoutCtl;
            8'h70: return dacCtl;
            8'h71: return dacData;
            8'h72: return firstLoCtl;
            8'h73: return pllPreload;
            8'h75: return spanAtten[7:0];
            8'h76: return spanAtten[15:8];
            8'h77: return preselCtl;
            8'h78: return videoOffset;
            8'h79: return {pulseStretch, identOffset, deflectMode, logScale};
            8'h7a: return storeWrData;
            8'h7b: return storeCtl;
            8'h7c: return videoProc;
            8'h7d: return auxSynth;
            default: return trackingAdjust;
        endcase
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        summarize();
    end

    initial begin
        errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        pllSelReset = 1'b0;
        psuStatus = 8'h3c;
        dacCompare = 8'hc5;
        panelEncoders = 8'h96;
        storeReadData = 8'h69;
        pllFlags = 8'h50;
        pllCounter = 24'h0ab1c2;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check("reset outputs", 16'({sweepCtl[7:0], rbwSelect, busRdValid, storeWrStb}), 16'h0000);
        $display("Test reset done");
        foreach (WR_ROWS[i]) begin
            host_u.wr(WR_ROWS[i].addr, WR_ROWS[i].data);
            @(negedge mclk);
            check($sformatf("reg %h", WR_ROWS[i].addr), 16'(seenFor(WR_ROWS[i].addr)), 16'(WR_ROWS[i].exp));
        end
        // Second pass catches a write that clobbered a neighbour
        foreach (WR_ROWS[i]) begin
            check($sformatf("kept %h", WR_ROWS[i].addr),
                16'(seenFor(WR_ROWS[i].addr)), 16'(WR_ROWS[i].exp));
        end
        $display("Test register table done");
        check("acq sub vert", 16'({storeAcqEn, storeSubAddr, storeVertical}), 16'h001d);
        check("base level", 16'({videoProc, 7'h00, baseLevelOn}), 16'h0101);
        host_u.wr(8'h7b, 8'h50);
        host_u.wr(8'h7c, 8'hfe);
        @(negedge mclk);
        check("acq sub vert", 16'({storeAcqEn, storeSubAddr, storeVertical}), 16'h000a);
        check("base level", 16'({videoProc, 7'h00, baseLevelOn}), 16'hfe00);
        foreach (STEER_DAT[i]) begin
            host_u.wr(8'h3f, STEER_DAT[i]);
            @(negedge mclk);
            check("rbw gain", 16'({rbwSelect, gainLevel}), 16'(STEER_EXP[i]));
        end
        $display("Test steering done");
        foreach (STB_ADR[i]) begin
            host_u.wr(STB_ADR[i], 8'h33);
            @(negedge mclk);
            check("strobes", 16'({storeWrStb, charStb, pllPreloadStb}), 16'(STB_EXP[i]));
            @(negedge mclk);
            check("strobes", 16'({storeWrStb, charStb, pllPreloadStb}), 16'h0000);
        end
        $display("Test strobes done");
        foreach (RD_ROWS[i]) begin
            host_u.rd(RD_ROWS[i].addr, rdVal, rdOk);
            check($sformatf("read %h", RD_ROWS[i].addr),
                16'({rdOk, rdVal}), 16'({1'b1, RD_ROWS[i].exp}));
        end
        host_u.rd(8'h77, rdVal, rdOk);
        check("read below 80", 16'(rdOk), 16'h0000);
        host_u.wr(8'hf8, 8'h11);
        @(negedge mclk);
        check("write above 80", 16'(videoOffset), 16'h00ff);
        $display("Test reads done");
        @(posedge mclk);
        pllSelReset <= 1'b1;
        @(posedge mclk);
        pllSelReset <= 1'b0;
        foreach (PLL_EXP[i]) begin
            host_u.rd(8'hf3, rdVal, rdOk);
            check("pll read", 16'({rdOk, rdVal}), 16'({1'b1, PLL_EXP[i]}));
        end
        $display("Test phase lock done");
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check("second reset", 16'({videoOffset, rbwSelect, storeAcqEn}), 16'h0000);
        $display("Test second reset done");
        summarize();
    end
endmodule // testbench
